// *** logic/sram_tap.sv ***
/*
 * Capture-only boundary-scan test access port of a synchronous memory.
 * Assumes CLK_I (20 MHz) oversamples the test clock, which runs far
 * slower, and that the pin ring sampler shares CLK_I.
 */
// Operation
// (R1) Inputs act at test clock rise; serial output changes at its fall.
// (R2) Mode-select and serial data input read high when left open.
// (R3) Serial data enters at register MSB, leaves from its LSB.
// (R4) Serial output driven only in shift states, otherwise high impedance.
// (R5) Five rises with mode-select high reset the controller; memory untouched.
// (R6) Power-up reset leaves serial output in high impedance.
// (R7) Unused port: outside holds test clock low, output unconnected.
// (R8) The instruction selects exactly one data register.
// (R9) Three-bit instruction, identification after power-up and reset.
// (R10) Capture-instruction loads 01 into the two low bits.
// (R11) New instruction takes effect only at update-instruction.
// (R12) Bypass bit is cleared to zero on capture.
// (R13) Bypass instruction puts the single bypass bit in the path.
// (R14) Boundary register captures pin ring, then shifts in shift-data.
// (R15) Identification instruction captures fixed 32-bit code, then shifts.
// (R16) All-zero instruction samples ring and forces memory outputs off.
// (R17) High-impedance sample selects boundary register, outputs forced off.
// (R18) Sample instruction snapshots pins at capture-data.
// (R19) Update-data under sample has no pin effect, like pause.
// (R20) Never drives memory pins; only capture and forced high impedance.
// (R21) Outside never loads the three reserved codes.
// (R22) Standard sixteen-state controller stepped by mode-select.
// (R23) Boundary length and bit order are build parameters; here only the length is, bit order follows RING_I wiring.
// (R24) Codes 000 external, 001 identification, 010 high-impedance sample.
// (R25) Identification bit 0 always reads one.
// (R26) Boundary register 71 bits narrow variant, 110 bits wide.
module sram_tap
    import sram_tap_pkg::*;
#(
    parameter int BSR_LEN = BSR_LEN_X36, // R23 R26
    parameter logic [ID_W-1:0] ID_CODE = ID_CODE_DEF
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire tap_pins_t TAP_I,
    input wire logic [BSR_LEN-1:0] RING_I,
    input wire logic RING_VALID_I,
    output logic RING_READY_O,
    output logic TDO_O,
    output logic TDO_OE_O,
    output logic MEM_HIGHZ_O
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    tap_pins_t pins_meta;
    tap_pins_t pins_sync;
    logic tck_prev;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            pins_meta <= PINS_IDLE; // R2
            pins_sync <= PINS_IDLE; // R2
            tck_prev <= 1'b0;
        end else begin
            pins_meta <= TAP_I;
            pins_sync <= pins_meta;
            tck_prev <= pins_sync.tck;
        end
    end

    wire tck_rise = pins_sync.tck & ~tck_prev;
    wire tck_fall = ~pins_sync.tck & tck_prev;
    wire tms = pins_sync.tms;
    wire tdi = pins_sync.tdi;

    // ------------------------------------------------------------
    // Controller
    // ------------------------------------------------------------
    tap_state_t state;
    wire tap_state_t next_state = tap_next(state, tms); // R22

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state <= TAP_RESET; // R6
        end else if (tck_rise) begin
            state <= next_state; // R1 R5 R22
        end
    end

    // ------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------
    logic [IR_W-1:0] ir_shift;
    logic [IR_W-1:0] instr;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ir_shift <= INS_ID;
            instr <= INS_ID; // R9
        end else if (tck_rise) begin
            if (state == CAP_IR) begin
                ir_shift <= {IR_CAPTURE_MSB, IR_CAPTURE_LOW}; // R10
            end else if (state == SHIFT_IR) begin
                ir_shift <= {tdi, ir_shift[IR_W-1:1]}; // R3
            end
            if (next_state == TAP_RESET) begin
                instr <= INS_ID; // R9
            end else if (state == UPD_IR) begin
                instr <= ir_shift; // R11
            end
        end
    end

    // ------------------------------------------------------------
    // Data register selection, exactly one at a time
    // ------------------------------------------------------------
    // Reserved codes fall to bypass so the path always has a register
    wire sel_bsr = (instr == INS_EXT_TEST) || (instr == INS_SAMPLE)
        || (instr == INS_HIZ_SAMPLE); // R8 R24
    wire sel_id = (instr == INS_ID); // R8 R24
    wire sel_byp = !sel_bsr && !sel_id; // R8 R13
    wire force_hiz = (instr == INS_EXT_TEST)
        || (instr == INS_HIZ_SAMPLE); // R16 R17

    wire dr_capture = tck_rise && (state == CAP_DR);
    wire dr_shift = tck_rise && (state == SHIFT_DR);

    // ------------------------------------------------------------
    // Ring sample buffer, two entries
    // ------------------------------------------------------------
    logic [BSR_LEN-1:0] ring_mem [RING_DEPTH];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] ring_count;
    wire ring_push = RING_VALID_I && RING_READY_O;
    wire ring_pop = dr_capture && sel_bsr && (ring_count != RING_EMPTY);
    wire [1:0] next_ring_count = 2'(ring_count + {1'b0, ring_push}
        - {1'b0, ring_pop});

    always_ff @(posedge CLK_I) begin
        if (ring_push) begin
            ring_mem[wr_ptr] <= RING_I;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            ring_count <= RING_EMPTY;
            RING_READY_O <= 1'b0;
        end else begin
            wr_ptr <= wr_ptr ^ ring_push;
            rd_ptr <= rd_ptr ^ ring_pop;
            ring_count <= next_ring_count;
            RING_READY_O <= (next_ring_count != RING_FULL);
        end
    end

    // ------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------
    // Bit order follows RING_I, so the pin order is fixed by wiring
    logic [BSR_LEN-1:0] bsr; // R23
    logic [ID_W-1:0] idr;
    logic byp;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            bsr <= '0;
            idr <= '0;
            byp <= BYPASS_CAPTURE;
        end else begin
            if (ring_pop) begin
                bsr <= ring_mem[rd_ptr]; // R14 R16 R18
            end else if (dr_shift && sel_bsr) begin
                bsr <= {tdi, bsr[BSR_LEN-1:1]}; // R3 R14 R17
            end
            if (dr_capture && sel_id) begin
                idr <= {ID_CODE[ID_W-1:1], 1'b1}; // R15 R25
            end else if (dr_shift && sel_id) begin
                idr <= {tdi, idr[ID_W-1:1]}; // R3 R15
            end
            if (dr_capture && sel_byp) begin
                byp <= BYPASS_CAPTURE; // R12
            end else if (dr_shift && sel_byp) begin
                byp <= tdi; // R13
            end
        end
    end

    // ------------------------------------------------------------
    // Serial output and memory output control
    // ------------------------------------------------------------
    wire dr_lsb = sel_bsr ? bsr[0] : (sel_id ? idr[0] : byp); // R3
    wire in_shift = (state == SHIFT_DR) || (state == SHIFT_IR);
    wire shift_bit = (state == SHIFT_IR) ? ir_shift[0] : dr_lsb;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            TDO_O <= 1'b0;
            TDO_OE_O <= 1'b0; // R6
        end else if (tck_fall) begin
            TDO_O <= in_shift ? shift_bit : TDO_O; // R1
            TDO_OE_O <= in_shift; // R4
        end
    end

    // Update-data has no pin effect: only the off-force leaves here
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            MEM_HIGHZ_O <= 1'b0;
        end else begin
            MEM_HIGHZ_O <= force_hiz; // R16 R17 R19 R20
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [2:0] tms_run;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            tms_run <= '0;
        end else if (tck_rise) begin
            if (!tms) begin
                tms_run <= '0;
            end else if (tms_run != RESET_TMS_EDGES) begin
                tms_run <= 3'(tms_run + 3'h1);
            end
        end
    end

    sequence s_ir_capture;
        tck_rise && state == CAP_IR;
    endsequence

    sequence s_id_capture;
        tck_rise && state == CAP_DR && sel_id;
    endsequence

    sequence s_byp_capture;
        tck_rise && state == CAP_DR && sel_byp;
    endsequence

    property p_tms_reset;
        @(posedge CLK_I) disable iff (RST_I)
        tms_run == RESET_TMS_EDGES |-> state == TAP_RESET;
    endproperty
    a_tms_reset: assert property (p_tms_reset) // R5
        else $error("five high mode-select rises did not reset");

    property p_reset_instr;
        @(posedge CLK_I) disable iff (RST_I)
        state == TAP_RESET |-> instr == INS_ID;
    endproperty
    a_reset_instr: assert property (p_reset_instr) // R9
        else $error("reset state without identification instruction");

    property p_ir_capture;
        @(posedge CLK_I) disable iff (RST_I)
        s_ir_capture |=> ir_shift[1:0] == IR_CAPTURE_LOW;
    endproperty
    a_ir_capture: assert property (p_ir_capture) // R10
        else $error("instruction capture pattern wrong");

    property p_instr_update;
        @(posedge CLK_I) disable iff (RST_I)
        $changed(instr) |-> $past(tck_rise)
            && ($past(state) == UPD_IR || state == TAP_RESET);
    endproperty
    a_instr_update: assert property (p_instr_update) // R11
        else $error("instruction changed outside update");

    property p_id_capture;
        @(posedge CLK_I) disable iff (RST_I)
        s_id_capture |=> idr[0] && idr == {ID_CODE[ID_W-1:1], 1'b1};
    endproperty
    a_id_capture: assert property (p_id_capture) // R15
        else $error("identification code not captured");

    property p_byp_capture;
        @(posedge CLK_I) disable iff (RST_I)
        s_byp_capture |=> !byp;
    endproperty
    a_byp_capture: assert property (p_byp_capture) // R12
        else $error("bypass bit not cleared on capture");

    property p_tdo_off;
        @(posedge CLK_I) disable iff (RST_I)
        tck_fall && !in_shift |=> !TDO_OE_O;
    endproperty
    a_tdo_off: assert property (p_tdo_off) // R4
        else $error("serial output driven outside shift");

    property p_tdo_edge;
        @(posedge CLK_I) disable iff (RST_I)
        $changed(TDO_O) || $rose(TDO_OE_O) |-> $past(tck_fall);
    endproperty
    a_tdo_edge: assert property (p_tdo_edge) // R1
        else $error("serial output changed away from falling edge");

    property p_hiz;
        @(posedge CLK_I) disable iff (RST_I)
        force_hiz ##1 force_hiz |-> MEM_HIGHZ_O;
    endproperty
    a_hiz: assert property (p_hiz) // R16
        else $error("memory outputs not forced off");

    property p_bsr_capture;
        @(posedge CLK_I) disable iff (RST_I)
        ring_pop |=> bsr == $past(ring_mem[rd_ptr]);
    endproperty
    a_bsr_capture: assert property (p_bsr_capture) // R14
        else $error("boundary register missed ring word");

endmodule

// *** logic/sram_tap_pkg.sv ***
/*
 * Shared types and constants of the memory test access port: controller
 * states, instruction codes, pin carrier and build defaults.
 * Assumes a single fast system clock that oversamples the test pins.
 */
package sram_tap_pkg;

    // ------------------------------------------------------------
    // Test pins as one carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } tap_pins_t;

    // Idle level of the pins: clock low, pulled-up inputs high
    localparam tap_pins_t PINS_IDLE = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};

    // ------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        TAP_RESET, RUN_IDLE,
        SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
        SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
    } tap_state_t;

    // ------------------------------------------------------------
    // Instructions
    // ------------------------------------------------------------
    localparam int IR_W = 3;
    localparam logic [IR_W-1:0] INS_EXT_TEST = 3'h0;
    localparam logic [IR_W-1:0] INS_ID = 3'h1;
    localparam logic [IR_W-1:0] INS_HIZ_SAMPLE = 3'h2;
    localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
    localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;
    localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;
    localparam logic IR_CAPTURE_MSB = 1'b0;
    localparam logic BYPASS_CAPTURE = 1'b0;

    // ------------------------------------------------------------
    // Sizes and identification
    // ------------------------------------------------------------
    localparam int ID_W = 32;
    // Arbitrary neutral code; only bit 0 (presence marker) is fixed
    localparam logic [ID_W-1:0] ID_CODE_DEF = 32'h0000_0001;
    localparam int BSR_LEN_X36 = 71;
    localparam int BSR_LEN_X72 = 110;
    localparam int RING_DEPTH = 2;
    localparam logic [1:0] RING_FULL = 2'h2;
    localparam logic [1:0] RING_EMPTY = 2'h0;
    localparam logic [2:0] RESET_TMS_EDGES = 3'h5;

    // ------------------------------------------------------------
    // Controller next state, decided by mode-select at a clock rise
    // ------------------------------------------------------------
    function automatic tap_state_t tap_next(tap_state_t s, logic tms);
        case (s)
            TAP_RESET: tap_next = tms ? TAP_RESET : RUN_IDLE;
            RUN_IDLE: tap_next = tms ? SEL_DR : RUN_IDLE;
            SEL_DR: tap_next = tms ? SEL_IR : CAP_DR;
            CAP_DR: tap_next = tms ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: tap_next = tms ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: tap_next = tms ? UPD_DR : PAUSE_DR;
            PAUSE_DR: tap_next = tms ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: tap_next = tms ? UPD_DR : SHIFT_DR;
            UPD_DR: tap_next = tms ? SEL_DR : RUN_IDLE;
            SEL_IR: tap_next = tms ? TAP_RESET : CAP_IR;
            CAP_IR: tap_next = tms ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: tap_next = tms ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: tap_next = tms ? UPD_IR : PAUSE_IR;
            PAUSE_IR: tap_next = tms ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: tap_next = tms ? UPD_IR : SHIFT_IR;
            UPD_IR: tap_next = tms ? SEL_DR : RUN_IDLE;
            default: tap_next = TAP_RESET;
        endcase
    endfunction

endpackage

// *** verif/sram_tap_tb.sv ***
/*
 * Testbench of the memory test port: scenario tasks step the controller
 * model, offer pin ring words and judge what is shifted back.
 * Assumes the design oversamples the test pins with CLK_I.
 */
module sram_tap_tb;
    import sram_tap_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int BSR = BSR_LEN_X36;
    // Arbitrary code; bit 0 left low so its forcing is visible
    localparam logic [31:0] ID = 32'h1234_5678;
    localparam logic [31:0] PAT = 32'hC3A5_0F96;

    logic clk = 1'b0;
    logic rst = 1'b1;
    tap_pins_t pins;
    logic [BSR-1:0] ring = '0;
    logic ring_valid = 1'b0;
    logic ring_ready, tdo, tdo_oe, mem_highz;
    int num_errors = 0;
    int n_checks = 0;

    always #25 clk = ~clk;

    sram_tap #(.BSR_LEN(BSR), .ID_CODE(ID)) u_dut (
        .CLK_I(clk), .RST_I(rst), .TAP_I(pins), .RING_I(ring),
        .RING_VALID_I(ring_valid), .RING_READY_O(ring_ready),
        .TDO_O(tdo), .TDO_OE_O(tdo_oe), .MEM_HIGHZ_O(mem_highz)
    );

    tap_ctl_model u_ctl (
        .CLK_I(clk), .TDO_I(tdo), .TDO_OE_I(tdo_oe), .PINS_O(pins)
    );

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [127:0] seen,
                         input logic [127:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic st(input logic tms, input logic tdi = 1'b1);
        logic b;
        u_ctl.step(tms, tdi, b);
    endtask

    // Shift n bits from shift state; last bit leaves with mode high
    task automatic scan(input int n, input logic [127:0] din,
                        output logic [127:0] dout);
        logic b;
        dout = '0;
        for (int i = 0; i < n; i++) begin
            u_ctl.step(i == n - 1, din[i], b);
            dout[i] = b;
        end
    endtask

    // Idle to shift-data and back to idle through update
    task automatic dr(input int n, input logic [127:0] din,
                      output logic [127:0] dout);
        st(1);
        st(0);
        st(0);
        scan(n, din, dout);
        st(1);
        st(0);
    endtask

    task automatic ir(input logic [IR_W-1:0] code, input logic hz);
        logic [127:0] o;
        st(1);
        st(1);
        st(0);
        st(0);
        scan(IR_W, code, o);
        check("ir capture", o[2:0], 3'h1);
        check("highz before update", mem_highz, hz);
        st(1);
        st(0);
    endtask

    task automatic push(input logic [BSR-1:0] w);
        tick();
        ring = w;
        ring_valid = 1'b1;
        for (int k = 0; ring_ready !== 1'b1; k++) begin
            if (k == 100) begin
                num_errors++;
                report_and_stop();
            end
            tick();
        end
        tick();
        ring_valid = 1'b0;
    endtask

    function automatic logic [BSR-1:0] word(input int i);
        return {7'(i + 1), 64'hF0E1_D2C3_B4A5_9687 ^ 64'(i)};
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_id();
        logic [127:0] o;
        st(0);
        dr(64, {96'h0, PAT}, o);
        check("idcode", o[63:0], {PAT, ID | 32'h1});
        check("highz id", mem_highz, 1'b0);
        u_ctl.park();
        repeat (6) tick();
        check("oe idle", tdo_oe, 1'b0);
        $display("done id");
    endtask

    task automatic t_bypass();
        logic [127:0] o;
        ir(INS_BYPASS, 1'b0);
        dr(8, 128'hB4, o);
        check("bypass", o[7:0], 8'h68);
        $display("done bypass");
    endtask

    task automatic t_ring();
        logic [127:0] o;
        logic [IR_W-1:0] c [3] = '{INS_EXT_TEST, INS_HIZ_SAMPLE, INS_SAMPLE};
        logic hz = 1'b0;
        for (int i = 0; i < 3; i++) begin
            ir(c[i], hz);
            hz = (i < 2);
            push(word(i));
            dr(BSR, '0, o);
            check("ring", o[BSR-1:0], word(i));
            check("highz", mem_highz, hz);
        end
        $display("done ring");
    endtask

    task automatic t_fifo();
        logic [127:0] o;
        push(word(4));
        push(word(5));
        repeat (2) tick();
        check("ready full", ring_ready, 1'b0);
        ring = word(6);
        ring_valid = 1'b1;
        dr(BSR, '0, o);
        check("fifo 0", o[BSR-1:0], word(4));
        tick();
        ring_valid = 1'b0;
        check("ready refill", ring_ready, 1'b0);
        dr(BSR, '0, o);
        check("fifo 1", o[BSR-1:0], word(5));
        dr(BSR, '0, o);
        check("fifo 2", o[BSR-1:0], word(6));
        repeat (2) tick();
        check("ready empty", ring_ready, 1'b1);
        $display("done fifo");
    endtask

    task automatic t_reset();
        ir(INS_EXT_TEST, 1'b0);
        // Off-force is registered one clock after the update rise
        repeat (2) tick();
        check("highz ext", mem_highz, 1'b1);
        st(1);
        st(0);
        st(0);
        repeat (5) st(1);
        u_ctl.park();
        repeat (6) tick();
        check("highz reset", mem_highz, 1'b0);
        check("oe reset", tdo_oe, 1'b0);
        t_id();
        $display("done reset");
    endtask

    initial begin
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (3) tick();
        check("oe power", tdo_oe, 1'b0);
        check("highz power", mem_highz, 1'b0);
        t_id();
        t_bypass();
        t_ring();
        t_fifo();
        t_reset();
        report_and_stop();
    end
endmodule

// *** verif/tap_ctl_model.sv ***
/*
 * Behavioural board-level test controller facing the test port.
 * Assumes the caller steps it from the CLK_I domain; one step is 400 ns.
 */
module tap_ctl_model
    import sram_tap_pkg::*;
(
    input wire logic CLK_I,
    input wire logic TDO_I,
    input wire logic TDO_OE_I,
    output tap_pins_t PINS_O
);
    timeunit 1ns;
    timeprecision 1ns;

    logic last_tdo = 1'b0;
    logic tdo_line;

    // Released line has no pull: show the inverse of the last bit
    assign tdo_line = TDO_OE_I ? TDO_I : ~last_tdo;

    always @(posedge CLK_I) begin
        if (TDO_OE_I)
            last_tdo <= TDO_I;
    end

    initial PINS_O = PINS_IDLE;

    // Clock low, open inputs high: port left unclocked
    task automatic park();
        @(posedge CLK_I);
        #1;
        PINS_O = PINS_IDLE;
    endtask

    // Fall, settle, sample the output just before the rise
    task automatic step(input logic tms, input logic tdi,
                        output logic tdo_s);
        @(posedge CLK_I);
        #1;
        PINS_O = '{tck: 1'b0, tms: tms, tdi: tdi};
        repeat (4) @(posedge CLK_I);
        #1;
        tdo_s = tdo_line;
        PINS_O.tck = 1'b1;
        repeat (3) @(posedge CLK_I);
    endtask
endmodule
